// *** rtl/pmwf_core.sv ***
// Bridge end: local master control and PCI master for a wide single write
//
// Notes on behaviour
// - Local wide request asserts reqn next clock
// - Grant plus idle bus asserts local grant
// - Request and grant seen: status Address Loading
// - Master withdraws request after Address Loading
// - Address phase: framen, req64n, address, command
// - Address phase loads beat counter with length
// - Ready master gives data; all three taken strobes assert
// - Master holds ready off until data ready
// - Drop reqn once framen on, request off
// - Strobed data and enables driven next clock
// - Local grant deasserts following arbiter grant
// - Narrow target: devseln, trdyn, no ack64n
// - Narrow target: clear wide flag, count two
// - devseln and ready seen: assert irdyn
// - framen stays until final data phase
// - irdyn with trdyn decrements beat counter
// - First word taken: high word moves low
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module pmwf_core (
  input wire logic ref_clk,
  input wire logic rst,
  pmwf_local_if.device lm,
  output logic pci_reqn,
  input wire logic pci_gntn,
  output logic pci_framen_o,
  output logic pci_framen_oe,
  input wire logic pci_framen_i,
  output logic pci_req64n_o,
  output logic pci_req64n_oe,
  output logic pci_irdyn_o,
  output logic pci_irdyn_oe,
  input wire logic pci_irdyn_i,
  output logic [pmwf_pkg::DATA_W-1:0] pci_ad_o,
  output logic pci_ad_oe,
  output logic [pmwf_pkg::BE_W-1:0] pci_cben_o,
  output logic pci_cben_oe,
  input wire logic pci_devseln_i,
  input wire logic pci_trdyn_i,
  input wire logic pci_ack64n_i
);
  import pmwf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {S_IDLE, S_REQ, S_GRANT, S_LOAD, S_ADDR, S_DATA, S_XFER, S_TURN} pmwf_core_phase_type;

  typedef struct packed {
    pmwf_core_phase_type phase;
    logic reqn;
    logic grant_n;
    logic [3:0] status;
    logic [ADDR_W-1:0] addr;
    logic [3:0] cmd;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] beat;
    logic wide_n;
    logic framen;
    logic req64n;
    logic irdyn;
    logic drive;
    logic [DATA_W-1:0] ad;
    logic [BE_W-1:0] cben;
    logic taken_n;
  } pmwf_core_state_type;

  localparam pmwf_core_state_type CORE_RESET = '{phase: S_IDLE, reqn: 1'b1, grant_n: 1'b1, status: PH_IDLE,
    wide_n: 1'b1, framen: 1'b1, req64n: 1'b1, irdyn: 1'b1, taken_n: 1'b1, default: '0};

  pmwf_core_state_type state_reg;
  pmwf_core_state_type state_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.taken_n = 1'b1;
    // Master keeps reqn only while it asks for a further transaction
    if (!state_reg.framen && lm.local_wide_request_n) begin
      state_next.reqn = 1'b1;
    end
    if (pci_gntn) begin
      state_next.grant_n = 1'b1;
    end
    if (!state_reg.irdyn && !pci_trdyn_i && state_reg.beat != '0) begin
      state_next.beat = state_reg.beat - 1'b1;
    end
    case (state_reg.phase)
      S_IDLE: begin
        if (!lm.local_wide_request_n) begin
          state_next.reqn = 1'b0;
          state_next.phase = S_REQ;
        end
      end
      S_REQ: begin
        // Bus idle means no other master still holds framen or irdyn
        if (!pci_gntn && pci_framen_i && pci_irdyn_i) begin
          state_next.grant_n = 1'b0;
          state_next.phase = S_GRANT;
        end
      end
      S_GRANT: begin
        if (!lm.local_wide_request_n && !pci_gntn) begin
          state_next.status = PH_ADDR_LOAD;
          state_next.addr = lm.addr_in;
          state_next.cmd = lm.local_cmd_byte_en_in[3:0];
          state_next.len = lm.local_beat_length_in;
          state_next.phase = S_LOAD;
        end else if (pci_gntn) begin
          state_next.phase = S_REQ;
        end
      end
      S_LOAD: begin
        if (!pci_gntn) begin
          state_next.framen = 1'b0;
          state_next.req64n = 1'b0;
          state_next.drive = 1'b1;
          state_next.ad = {32'h0000_0000, state_reg.addr};
          state_next.cben = {4'h0, state_reg.cmd};
          state_next.status = PH_BUS_TRANS;
          state_next.beat = state_reg.len;
          state_next.wide_n = 1'b0;
          state_next.phase = S_ADDR;
          if (!lm.local_ready_n) begin
            state_next.taken_n = 1'b0;
          end
        end else begin
          // Grant lost before the address phase: ask again
          state_next.status = PH_IDLE;
          state_next.phase = S_REQ;
        end
      end
      S_ADDR: begin
        if (!state_reg.taken_n) begin
          state_next.ad = lm.data_in;
          state_next.cben = lm.local_cmd_byte_en_in;
          state_next.phase = S_DATA;
        end else if (!lm.local_ready_n) begin
          state_next.taken_n = 1'b0;
        end
      end
      S_DATA: begin
        if (!pci_devseln_i) begin
          if (pci_ack64n_i) begin
            state_next.wide_n = 1'b1;
            state_next.beat = NARROW_BEATS[LEN_W-1:0];
          end
          if (!lm.local_ready_n) begin
            state_next.irdyn = 1'b0;
            // A wide target takes everything in one final phase
            if (!pci_ack64n_i) begin
              state_next.framen = 1'b1;
              state_next.req64n = 1'b1;
            end
            state_next.phase = S_XFER;
          end
        end
      end
      S_XFER: begin
        if (!state_reg.irdyn && !pci_trdyn_i) begin
          if (state_reg.wide_n && state_reg.beat > 1) begin
            state_next.ad[31:0] = state_reg.ad[63:32];
            state_next.cben[3:0] = state_reg.cben[7:4];
            state_next.framen = 1'b1;
            state_next.req64n = 1'b1;
          end else begin
            state_next.irdyn = 1'b1;
            state_next.framen = 1'b1;
            state_next.req64n = 1'b1;
            state_next.status = PH_IDLE;
            state_next.wide_n = 1'b1;
            state_next.phase = S_TURN;
          end
        end
      end
      S_TURN: begin
        // One cycle driving the controls high before letting go of the bus
        state_next.drive = 1'b0;
        state_next.phase = S_IDLE;
      end
      default: begin
        state_next = CORE_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= CORE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign lm.local_grant_n = state_reg.grant_n;
  assign lm.local_phase_status = state_reg.status;
  assign lm.local_beat_counter = state_reg.beat;
  assign lm.low_word_taken_n = state_reg.taken_n;
  assign lm.low_word_taken_alt_n = state_reg.taken_n;
  assign lm.high_word_taken_n = state_reg.taken_n;
  assign lm.wide_transfer_active_n = state_reg.wide_n;
  assign pci_reqn = state_reg.reqn;
  assign pci_framen_o = state_reg.framen;
  assign pci_framen_oe = state_reg.drive;
  assign pci_req64n_o = state_reg.req64n;
  assign pci_req64n_oe = state_reg.drive;
  assign pci_irdyn_o = state_reg.irdyn;
  assign pci_irdyn_oe = state_reg.drive;
  assign pci_ad_o = state_reg.ad;
  assign pci_ad_oe = state_reg.drive;
  assign pci_cben_o = state_reg.cben;
  assign pci_cben_oe = state_reg.drive;
endmodule
`default_nettype wire

// *** rtl/pmwf_lmaster.sv ***
// Local master end: register port, write data FIFO and request sequencing
`timescale 1ns/10ps
`default_nettype none
module pmwf_fifo #(
  parameter int W = 72,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } pmwf_fifo_state_type;

  pmwf_fifo_state_type state_reg;
  pmwf_fifo_state_type state_next;
  logic push;
  logic pop;

  assign in_ready = state_reg.cnt != DEPTH[AW:0];
  assign out_valid = state_reg.cnt != '0;
  assign out_data = state_reg.mem[state_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wp] = in_data;
      state_next.wp = (state_reg.wp == AW'(DEPTH - 1)) ? '0 : state_reg.wp + 1'b1;
    end
    if (pop) begin
      state_next.rp = (state_reg.rp == AW'(DEPTH - 1)) ? '0 : state_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      state_next.cnt = state_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      state_next.cnt = state_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module pmwf_lmaster (
  input wire logic ref_clk,
  input wire logic rst,
  pmwf_local_if.master lm,
  input wire logic [pmwf_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import pmwf_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_REQ, H_RUN} pmwf_lm_phase_type;

  typedef struct packed {
    pmwf_lm_phase_type phase;
    logic req_n;
    logic [ADDR_W-1:0] addr;
    logic [3:0] cmd;
    logic [LEN_W-1:0] len;
    logic [31:0] data_lo;
    logic [BE_W-1:0] byte_en;
    logic [31:0] rdata;
    logic sent;
  } pmwf_lm_state_type;

  localparam pmwf_lm_state_type LM_RESET = '{phase: H_IDLE, req_n: 1'b1, default: '0};

  pmwf_lm_state_type state_reg;
  pmwf_lm_state_type state_next;
  logic fifo_push;
  logic fifo_in_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic [FIFO_W-1:0] fifo_data;
  logic [31:0] status_word;

  // A word pair is pushed by the high-word write; a full FIFO drops it
  pmwf_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) data_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({state_reg.byte_en, reg_wdata, state_reg.data_lo}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign fifo_push = reg_wr && reg_addr == REG_DATA_HI;
  assign fifo_pop = !lm.low_word_taken_n && !lm.high_word_taken_n;

  always_comb begin
    status_word = '0;
    status_word[3:0] = lm.local_phase_status;
    status_word[STAT_BUSY_BIT] = state_reg.phase != H_IDLE;
    status_word[STAT_WIDE_BIT] = !lm.wide_transfer_active_n;
    status_word[STAT_EMPTY_BIT] = !fifo_valid;
    status_word[STAT_FULL_BIT] = !fifo_in_ready;
    status_word[STAT_BEAT_LSB +: LEN_W] = lm.local_beat_counter;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.rdata = '0;
    if (fifo_pop) begin
      state_next.sent = 1'b1;
    end
    if (reg_wr) begin
      case (reg_addr)
        REG_ADDR: state_next.addr = reg_wdata;
        REG_CMD: state_next.cmd = reg_wdata[3:0];
        REG_LEN: state_next.len = reg_wdata[LEN_W-1:0];
        REG_DATA_LO: state_next.data_lo = reg_wdata;
        REG_BYTE_EN: state_next.byte_en = reg_wdata[BE_W-1:0];
        REG_CTRL: begin
          if (reg_wdata[CTRL_START_BIT] && state_reg.phase == H_IDLE) begin
            state_next.req_n = 1'b0;
            state_next.phase = H_REQ;
          end
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_ADDR: state_next.rdata = state_reg.addr;
        REG_CMD: state_next.rdata = {28'h000_0000, state_reg.cmd};
        REG_LEN: state_next.rdata = {{(32 - LEN_W){1'b0}}, state_reg.len};
        REG_DATA_LO: state_next.rdata = state_reg.data_lo;
        REG_BYTE_EN: state_next.rdata = {24'h00_0000, state_reg.byte_en};
        REG_STATUS: state_next.rdata = status_word;
        default: state_next.rdata = '0;
      endcase
    end
    case (state_reg.phase)
      H_IDLE: begin
      end
      H_REQ: begin
        if (lm.local_phase_status == PH_ADDR_LOAD) begin
          state_next.req_n = 1'b1;
          state_next.phase = H_RUN;
        end
      end
      H_RUN: begin
        if (lm.local_phase_status == PH_IDLE) begin
          state_next.sent = 1'b0;
          state_next.phase = H_IDLE;
        end
      end
      default: begin
        state_next = LM_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= LM_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata = state_reg.rdata;
  assign lm.local_wide_request_n = state_reg.req_n;
  assign lm.addr_in = state_reg.addr;
  assign lm.local_beat_length_in = state_reg.len;
  // Command shares the byte-enable lines until the address is latched
  assign lm.local_cmd_byte_en_in = (state_reg.phase == H_REQ) ? {4'h0, state_reg.cmd} : fifo_data[71:64];
  assign lm.data_in = fifo_data[63:0];
  // Ready once a word pair waits, and held after hand-over: the last entry must not stall the data phase
  assign lm.local_ready_n = !((fifo_valid || state_reg.sent) && state_reg.phase != H_IDLE);
endmodule
`default_nettype wire

// *** rtl/pmwf_local_if.sv ***
// Local master link between the bridge and the user-side local master
`timescale 1ns/10ps
`default_nettype none
interface pmwf_local_if;
  logic local_wide_request_n;
  logic [pmwf_pkg::ADDR_W-1:0] addr_in;
  logic [pmwf_pkg::BE_W-1:0] local_cmd_byte_en_in;
  logic [pmwf_pkg::LEN_W-1:0] local_beat_length_in;
  logic local_ready_n;
  logic [pmwf_pkg::DATA_W-1:0] data_in;
  logic local_grant_n;
  logic [3:0] local_phase_status;
  logic [pmwf_pkg::LEN_W-1:0] local_beat_counter;
  logic low_word_taken_n;
  logic low_word_taken_alt_n;
  logic high_word_taken_n;
  logic wide_transfer_active_n;
  modport device (
    input local_wide_request_n, addr_in, local_cmd_byte_en_in, local_beat_length_in, local_ready_n, data_in,
    output local_grant_n, local_phase_status, local_beat_counter, low_word_taken_n, low_word_taken_alt_n,
    output high_word_taken_n, wide_transfer_active_n
  );
  modport master (
    output local_wide_request_n, addr_in, local_cmd_byte_en_in, local_beat_length_in, local_ready_n, data_in,
    input local_grant_n, local_phase_status, local_beat_counter, low_word_taken_n, low_word_taken_alt_n,
    input high_word_taken_n, wide_transfer_active_n
  );
endinterface
`default_nettype wire

// *** rtl/pmwf_pkg.sv ***
// Shared constants for the wide-write fallback bridge and its local master
package pmwf_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int BE_W = 8;
  localparam int LEN_W = 8;
  localparam int FIFO_W = 72;
  localparam int FIFO_DEPTH = 32;
  // Local phase status codes
  localparam logic [3:0] PH_IDLE = 4'h0;
  localparam logic [3:0] PH_ADDR_LOAD = 4'h1;
  localparam logic [3:0] PH_BUS_TRANS = 4'h2;
  // Beats of a wide write split for a narrow target
  localparam logic [7:0] NARROW_BEATS = 8'h02;
  // Local master register map (word index on reg_addr)
  localparam int REG_AW = 3;
  localparam logic [2:0] REG_ADDR = 3'h0;
  localparam logic [2:0] REG_CMD = 3'h1;
  localparam logic [2:0] REG_LEN = 3'h2;
  localparam logic [2:0] REG_DATA_LO = 3'h3;
  localparam logic [2:0] REG_DATA_HI = 3'h4;
  localparam logic [2:0] REG_BYTE_EN = 3'h5;
  localparam logic [2:0] REG_CTRL = 3'h6;
  localparam logic [2:0] REG_STATUS = 3'h7;
  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_WIDE_BIT = 5;
  localparam int STAT_EMPTY_BIT = 6;
  localparam int STAT_FULL_BIT = 7;
  localparam int STAT_BEAT_LSB = 8;
endpackage

// *** tb/pmwf_chk.sv ***
// Concurrent checks on the local link and PCI pins joining the two ends
`timescale 1ns/10ps
`default_nettype none
module pmwf_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic local_wide_request_n,
  input wire logic [pmwf_pkg::ADDR_W-1:0] addr_in,
  input wire logic [pmwf_pkg::BE_W-1:0] local_cmd_byte_en_in,
  input wire logic [pmwf_pkg::LEN_W-1:0] local_beat_length_in,
  input wire logic local_ready_n,
  input wire logic [pmwf_pkg::DATA_W-1:0] data_in,
  input wire logic local_grant_n,
  input wire logic [3:0] local_phase_status,
  input wire logic [pmwf_pkg::LEN_W-1:0] local_beat_counter,
  input wire logic low_word_taken_n,
  input wire logic low_word_taken_alt_n,
  input wire logic high_word_taken_n,
  input wire logic wide_transfer_active_n,
  input wire logic pci_reqn,
  input wire logic pci_gntn,
  input wire logic pci_framen_o,
  input wire logic pci_framen_oe,
  input wire logic pci_framen_i,
  input wire logic pci_req64n_o,
  input wire logic pci_irdyn_o,
  input wire logic pci_irdyn_oe,
  input wire logic pci_irdyn_i,
  input wire logic [pmwf_pkg::DATA_W-1:0] pci_ad_o,
  input wire logic pci_ad_oe,
  input wire logic [pmwf_pkg::BE_W-1:0] pci_cben_o,
  input wire logic pci_devseln_i,
  input wire logic pci_trdyn_i,
  input wire logic pci_ack64n_i
);
  import pmwf_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_addr_load;
    local_phase_status == PH_ADDR_LOAD && !pci_gntn;
  endsequence
  sequence s_phase_done;
    !pci_irdyn_o && pci_irdyn_oe && !pci_trdyn_i;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_req_follows: assert property ($fell(local_wide_request_n) |=> !pci_reqn)
    else $error("reqn not asserted after local request");
  a_grant_on_idle: assert property ($fell(local_grant_n) |-> !$past(pci_gntn) && $past(pci_framen_i) && $past(pci_irdyn_i))
    else $error("local grant without arbiter grant on idle bus");
  a_load_cause: assert property (local_phase_status == PH_ADDR_LOAD |-> !$past(local_wide_request_n) && !$past(pci_gntn))
    else $error("address loading without request and grant");
  a_addr_phase: assert property (s_addr_load |=> !pci_framen_o && !pci_req64n_o && pci_ad_oe
    && pci_ad_o[31:0] == $past(addr_in) && pci_cben_o[3:0] == $past(local_cmd_byte_en_in[3:0])
    && local_phase_status == PH_BUS_TRANS) else $error("address phase wrong");
  a_beat_load: assert property (s_addr_load |=> local_beat_counter == $past(local_beat_length_in))
    else $error("beat counter not loaded with length");
  a_data_moves: assert property (!low_word_taken_n |-> !high_word_taken_n && !low_word_taken_alt_n
    ##1 pci_ad_o == $past(data_in) && pci_cben_o == $past(local_cmd_byte_en_in)) else $error("taken data not driven");
  a_reqn_drop: assert property (!pci_framen_o && pci_framen_oe && local_wide_request_n |=> pci_reqn)
    else $error("reqn kept after frame start");
  a_grant_track: assert property (pci_gntn && !local_grant_n |=> local_grant_n)
    else $error("local grant does not follow arbiter");
  a_narrow_seen: assert property ($fell(pci_devseln_i) && pci_ack64n_i
    |=> wide_transfer_active_n && local_beat_counter == NARROW_BEATS) else $error("narrow target not handled");
  a_irdy_start: assert property ($fell(pci_devseln_i) && !local_ready_n |=> !pci_irdyn_o)
    else $error("irdyn not asserted after select");
  a_frame_held: assert property (wide_transfer_active_n && local_beat_counter == NARROW_BEATS
    && !pci_irdyn_o && pci_irdyn_oe |-> !pci_framen_o) else $error("framen dropped before final phase");
  a_beat_count: assert property (s_phase_done ##0 local_beat_counter != 8'h00
    |=> local_beat_counter == $past(local_beat_counter) - 8'h01) else $error("beat counter not decremented");
  a_second_word: assert property (s_phase_done ##0 wide_transfer_active_n && local_beat_counter == NARROW_BEATS
    |=> pci_ad_o[31:0] == $past(pci_ad_o[63:32]) && pci_cben_o[3:0] == $past(pci_cben_o[7:4]) && pci_framen_o)
    else $error("second word not moved down");
  a_release: assert property (s_phase_done ##0 local_beat_counter == 8'h01
    |=> pci_irdyn_o && pci_framen_o && local_phase_status == PH_IDLE) else $error("no release after last phase");
endmodule
`default_nettype wire

// *** tb/pmwf_tb.sv ***
// Testbench joining bridge and local master against a behavioural PCI arbiter and target
`timescale 1ns/10ps
`default_nettype none
module pmwf_tb;
  import pmwf_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic pci_gntn = 1'b1, pci_devseln_i = 1'b1, pci_trdyn_i = 1'b1, pci_ack64n_i = 1'b1;
  logic pci_reqn, pci_framen_o, pci_framen_oe, pci_req64n_o, pci_req64n_oe, pci_irdyn_o, pci_irdyn_oe;
  logic pci_ad_oe, pci_cben_oe;
  logic [DATA_W-1:0] pci_ad_o;
  logic [BE_W-1:0] pci_cben_o;
  logic [REG_AW-1:0] reg_addr = 3'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic frame_q = 1'b1, wide_mode = 1'b0, nph = 1'b0;
  logic [FIFO_W-1:0] cap_word = '0;
  logic [31:0] cap_addr = 32'h0;
  logic [3:0] cap_cmd = 4'h0;
  int errors = 0, n_compared = 0;
  // Control lines carry pull-ups, so a released line reads high
  wire logic pci_framen_i = pci_framen_oe ? pci_framen_o : 1'b1;
  wire logic pci_irdyn_i = pci_irdyn_oe ? pci_irdyn_o : 1'b1;
  pmwf_local_if lm_if ();
  pmwf_core pmwf_core_inst (.ref_clk, .rst, .lm(lm_if), .pci_reqn, .pci_gntn, .pci_framen_o, .pci_framen_oe,
    .pci_framen_i, .pci_req64n_o, .pci_req64n_oe, .pci_irdyn_o, .pci_irdyn_oe, .pci_irdyn_i, .pci_ad_o, .pci_ad_oe,
    .pci_cben_o, .pci_cben_oe, .pci_devseln_i, .pci_trdyn_i, .pci_ack64n_i);
  pmwf_lmaster pmwf_lmaster_inst (.ref_clk, .rst, .lm(lm_if), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  pmwf_chk pmwf_chk_inst (.ref_clk, .rst, .local_wide_request_n(lm_if.local_wide_request_n), .addr_in(lm_if.addr_in),
    .local_cmd_byte_en_in(lm_if.local_cmd_byte_en_in), .local_beat_length_in(lm_if.local_beat_length_in),
    .local_ready_n(lm_if.local_ready_n), .data_in(lm_if.data_in), .local_grant_n(lm_if.local_grant_n),
    .local_phase_status(lm_if.local_phase_status), .local_beat_counter(lm_if.local_beat_counter),
    .low_word_taken_n(lm_if.low_word_taken_n), .low_word_taken_alt_n(lm_if.low_word_taken_alt_n),
    .high_word_taken_n(lm_if.high_word_taken_n), .wide_transfer_active_n(lm_if.wide_transfer_active_n),
    .pci_reqn, .pci_gntn, .pci_framen_o, .pci_framen_oe, .pci_framen_i, .pci_req64n_o, .pci_irdyn_o, .pci_irdyn_oe,
    .pci_irdyn_i, .pci_ad_o, .pci_ad_oe, .pci_cben_o, .pci_devseln_i, .pci_trdyn_i, .pci_ack64n_i);
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Arbiter grants a clock after reqn; target decodes fast and is always ready
  always @(posedge ref_clk) begin
    pci_gntn <= pci_reqn;
    frame_q <= pci_framen_i;
    if (!pci_framen_i && frame_q) begin
      cap_addr <= pci_ad_o[31:0];
      cap_cmd <= pci_cben_o[3:0];
      pci_devseln_i <= 1'b0;
      pci_trdyn_i <= 1'b0;
      pci_ack64n_i <= ~wide_mode;
      nph <= 1'b0;
    end
    if (!pci_irdyn_i && !pci_trdyn_i) begin
      if (wide_mode) cap_word <= {pci_cben_o, pci_ad_o};
      else if (!nph) {cap_word[67:64], cap_word[31:0]} <= {pci_cben_o[3:0], pci_ad_o[31:0]};
      else {cap_word[71:68], cap_word[63:32]} <= {pci_cben_o[3:0], pci_ad_o[31:0]};
      nph <= 1'b1;
      if (pci_framen_i) {pci_devseln_i, pci_trdyn_i, pci_ack64n_i} <= 3'h7;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [FIFO_W-1:0] exp_word(input int i);
    return {i[7:0], 32'hEEEE0000 | i[31:0], 32'h11110000 | i[31:0]};
  endfunction
  task automatic check(input string what, input logic [FIFO_W-1:0] exp, input logic [FIFO_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [REG_AW-1:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // One start drains one FIFO entry; odd entries meet a wide target, even ones a narrow one
  task automatic run_one(input int i);
    logic [31:0] v;
    int k;
    wide_mode <= i[0];
    reg_write(REG_ADDR, 32'h40000000 + 32'(i * 8));
    reg_write(REG_CTRL, 32'h1);
    v = 32'h10;
    k = 0;
    while (v[STAT_BUSY_BIT] !== 1'b0 && k < 50) begin
      reg_read(REG_STATUS, v);
      k++;
    end
    check("busy", 72'h0, v[STAT_BUSY_BIT]);
    check("phase", 72'(PH_IDLE), v[3:0]);
    check("addr", 72'h40000000 + 72'(i * 8), cap_addr);
    check("cmd", 72'h7, cap_cmd);
    check("data", exp_word(i), cap_word);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [FIFO_W-1:0] w;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    reg_read(REG_STATUS, v);
    check("status at reset", 72'h40, v);
    reg_read(REG_CTRL, v);
    check("unmapped read", 72'h0, v);
    reg_write(REG_CMD, 32'h7);
    reg_write(REG_LEN, 32'h1);
    reg_read(REG_CMD, v);
    check("cmd reg", 72'h7, v);
    reg_read(REG_LEN, v);
    check("len reg", 72'h1, v);
    // One entry past the depth: it must be dropped, not overwrite the head
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      w = exp_word(i);
      reg_write(REG_DATA_LO, w[31:0]);
      reg_write(REG_BYTE_EN, {24'h0, w[71:64]});
      reg_write(REG_DATA_HI, w[63:32]);
    end
    reg_read(REG_STATUS, v);
    check("status full", 72'h80, v);
    reg_read(REG_DATA_LO, v);
    check("low word reg", 72'(w[31:0]), v);
    reg_read(REG_BYTE_EN, v);
    check("byte enable reg", 72'(w[71:64]), v);
    reg_read(REG_DATA_HI, v);
    check("write-only read", 72'h0, v);
    for (int i = 0; i < FIFO_DEPTH; i++) run_one(i);
    reg_read(REG_STATUS, v);
    check("status drained", 72'h40, v);
    reg_read(REG_ADDR, v);
    check("addr reg", 72'h400000F8, v);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
